// ===== core/nand_defines.svh
// Constants for the NAND host controller: command codes, status bits,
// array sizes and pin timing. Assumes core_clk runs at 100 MHz.
`ifndef NAND_DEFINES_SVH
`define NAND_DEFINES_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_READ1   8'h00
`define CMD_READ2   8'h30
`define CMD_SDIN    8'h80
`define CMD_PROG    8'h10
`define CMD_ERASE1  8'h60
`define CMD_ERASE2  8'hD0
`define CMD_STATUS  8'h70
`define CMD_RESET   8'hFF

// ----------------------------------------
// Status byte fields and markers
// ----------------------------------------
`define ST_FAIL     0
`define ST_REWRITE  3
`define ST_NWP      7
`define BAD_MARK    8'h00

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define PAGE_BYTES  13'h1080
`define BAD_COLUMN  13'h1000
`define NUM_BLOCKS  4096
`define MAX_PARTIAL 3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define T_HALF_NS     50
`define HALF_CYC      ((`T_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WB_NS       100
`define WB_CYC        ((`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/nand_pkg.sv
// Types shared by the NAND host controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package nand_pkg;
  // User operations
  typedef enum logic [2:0] {OP_RESET, OP_READ, OP_PROG, OP_ERASE, OP_SCAN} op_t;

  // Per-block bookkeeping record
  typedef struct packed {
    logic       bad;
    logic [6:0] next_page;
    logic [2:0] pcount;
  } blk_rec_t;

  // Sequencer phases
  typedef enum logic [3:0] {
    PH_INIT, PH_IDLE, PH_LOOKUP, PH_CHECK, PH_CMD1, PH_ADDR, PH_DIN,
    PH_CMD2, PH_WAITRB, PH_STCMD, PH_STRD, PH_RDCMD, PH_DOUT, PH_FINISH
  } phase_t;
endpackage
`default_nettype wire

// ===== core/nand_table_if.sv
// Carrier between the sequencer and its block table.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface nand_table_if #(parameter int BLK_W = 12);
  logic [BLK_W-1:0]  rd_blk;
  nand_pkg::blk_rec_t rd_rec;
  logic              wr_en;
  logic [BLK_W-1:0]  wr_blk;
  nand_pkg::blk_rec_t wr_rec;
  logic              ready;

  modport ctrl  (output rd_blk, wr_en, wr_blk, wr_rec, input rd_rec, ready);
  modport store (input rd_blk, wr_en, wr_blk, wr_rec, output rd_rec, ready);
endinterface
`default_nettype wire

// ===== core/nand_pin_sync.sv
// Pin input synchronisers and the pin cycle divider.
// Assumes io and ready/busy pins are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "nand_defines.svh"
module nand_pin_sync #(
  parameter int HALF_CYC = `HALF_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] io_in,
  input  wire logic       rb_in,
  output var  logic [7:0] io_sync,
  output var  logic       rb_sync,
  output var  logic       tick
);
  typedef struct packed {
    logic [7:0] io_meta;
    logic [7:0] io_sync;
    logic       rb_meta;
    logic       rb_sync;
    logic [7:0] div;
    logic       tick;
  } state_t;

  state_t s;
  state_t n;

  // Two flops per pin; divider gives one tick per half pin cycle
  always_comb begin
    n         = s;
    n.io_meta = io_in;
    n.io_sync = s.io_meta;
    n.rb_meta = rb_in;
    n.rb_sync = s.rb_meta;
    n.tick    = 1'b0;
    if (s.div == 8'(HALF_CYC - 1)) begin
      n.div  = 8'h00;
      n.tick = 1'b1;
    end else begin
      n.div = s.div + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign io_sync = s.io_sync;
  assign rb_sync = s.rb_sync;
  assign tick    = s.tick;
endmodule
`default_nettype wire

// ===== core/nand_block_table.sv
// Per-block record store: bad flag, next page to program, partial count.
// Assumes the sequencer waits for ready while the store self-clears.
`timescale 1ns/1ps
`default_nettype none
`include "nand_defines.svh"
module nand_block_table #(
  parameter int NUM_BLOCKS = `NUM_BLOCKS,
  parameter int BLK_W      = 12
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  nand_table_if.store tbl
);
  typedef struct packed {
    logic               clearing;
    logic [BLK_W-1:0]   idx;
    nand_pkg::blk_rec_t rd_rec;
  } state_t;

  state_t             s;
  state_t             n;
  nand_pkg::blk_rec_t mem [NUM_BLOCKS];

  // Sweep clears one entry a cycle after reset; reads lag one cycle
  always_comb begin
    n        = s;
    n.rd_rec = mem[tbl.rd_blk];
    if (s.clearing) begin
      n.idx = s.idx + BLK_W'(1);
      if (s.idx == BLK_W'(NUM_BLOCKS - 1)) begin
        n.clearing = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s          <= '0;
      s.clearing <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Memories: no reset, the sweep stands in for one
  always_ff @(posedge core_clk) begin
    if (s.clearing) begin
      mem[s.idx] <= '0;
    end else if (tbl.wr_en) begin
      mem[tbl.wr_blk] <= tbl.wr_rec;
    end
  end

  assign tbl.rd_rec = s.rd_rec;
  assign tbl.ready  = !s.clearing;
endmodule
`default_nettype wire

// ===== core/nand_host_ctrl.sv
// Host-side NAND controller: sequences commands, addresses and data
// on the flash pins and keeps a bad block and page order table.
// Assumes an external pull-up on ready/busy and one device on ce_n.
`timescale 1ns/1ps
`default_nettype none
`include "nand_defines.svh"
module nand_host_ctrl #(
  parameter int          BLK_W      = 12,
  parameter int          NUM_BLOCKS = `NUM_BLOCKS,
  parameter logic [12:0] PAGE_BYTES = `PAGE_BYTES,
  parameter logic [12:0] BAD_COLUMN = `BAD_COLUMN,
  parameter int          HALF_CYC   = `HALF_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             cmd_valid,
  output var  logic             cmd_ready,
  input  wire logic [2:0]       cmd_op,
  input  wire logic [BLK_W-1:0] cmd_block,
  input  wire logic [5:0]       cmd_page,
  input  wire logic [7:0]       wr_data,
  input  wire logic             wr_valid,
  output var  logic             wr_ready,
  output var  logic [7:0]       rd_data,
  output var  logic             rd_valid,
  output var  logic             done,
  output var  logic             res_fail,
  output var  logic             res_refused,
  output var  logic             res_rewrite,
  output var  logic             res_bad,
  output var  logic [7:0]       res_status,
  output var  logic             cle,
  output var  logic             ale,
  output var  logic             ce_n,
  output var  logic             we_n,
  output var  logic             read_strobe_n,
  output var  logic             wp_n,
  output var  logic [7:0]       io_out,
  output var  logic             io_oe,
  input  wire logic [7:0]       io_in,
  input  wire logic             ready_busy_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    nand_pkg::phase_t   phase;
    nand_pkg::op_t      op;
    logic               boot;
    logic [BLK_W-1:0]   blk;
    logic [5:0]         pg;
    logic [12:0]        col;
    logic               half;
    logic [12:0]        cnt;
    logic [12:0]        fcnt;
    logic [2:0]         aidx;
    logic [3:0]         wcnt;
    logic [7:0]         hold;
    logic               hold_full;
    logic [7:0]         status;
    logic               cle;
    logic               ale;
    logic               ce_n;
    logic               we_n;
    logic               re_n;
    logic               wp_n;
    logic [7:0]         io_out;
    logic               io_oe;
    logic               cmd_ready;
    logic               wr_ready;
    logic [7:0]         rd_data;
    logic               rd_valid;
    logic               done;
    logic               res_fail;
    logic               res_refused;
    logic               res_rewrite;
    logic               res_bad;
    logic               tbl_wr;
    nand_pkg::blk_rec_t tbl_rec;
  } state_t;

  state_t             s;
  state_t             n;
  logic [7:0]         io_sync;
  logic               rb_sync;
  logic               tick;
  logic               adv;
  logic               is_wr;
  logic               stall;
  logic [7:0]         wbyte;
  logic [12:0]        len;
  logic               refuse;
  nand_pkg::blk_rec_t rec;

  nand_table_if #(.BLK_W(BLK_W)) tbl ();

  nand_pin_sync #(.HALF_CYC(HALF_CYC)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .io_in    (io_in),
    .rb_in    (ready_busy_out),
    .io_sync  (io_sync),
    .rb_sync  (rb_sync),
    .tick     (tick)
  );

  nand_block_table #(.NUM_BLOCKS(NUM_BLOCKS), .BLK_W(BLK_W)) u_table (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tbl      (tbl)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // First and second command byte of each operation
  function automatic logic [7:0] first_cmd(input nand_pkg::op_t op);
    case (op)
      nand_pkg::OP_RESET: first_cmd = `CMD_RESET;
      nand_pkg::OP_PROG:  first_cmd = `CMD_SDIN;
      nand_pkg::OP_ERASE: first_cmd = `CMD_ERASE1;
      default:            first_cmd = `CMD_READ1;
    endcase
  endfunction

  function automatic logic [7:0] second_cmd(input nand_pkg::op_t op);
    case (op)
      nand_pkg::OP_PROG:  second_cmd = `CMD_PROG;
      nand_pkg::OP_ERASE: second_cmd = `CMD_ERASE2;
      default:            second_cmd = `CMD_READ2;
    endcase
  endfunction

  // Two column bytes then three row bytes
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [12:0] col,
                                           input logic [23:0] row);
    case (idx)
      3'h0:    addr_byte = col[7:0];
      3'h1:    addr_byte = {3'h0, col[12:8]};
      3'h2:    addr_byte = row[7:0];
      3'h3:    addr_byte = row[15:8];
      default: addr_byte = row[23:16];
    endcase
  endfunction

  // Byte to drive in each write phase
  always_comb begin
    case (s.phase)
      nand_pkg::PH_CMD1:  wbyte = first_cmd(s.op);
      nand_pkg::PH_ADDR:  wbyte = addr_byte(s.aidx, s.col, 24'({s.blk, s.pg}));
      nand_pkg::PH_DIN:   wbyte = s.hold;
      nand_pkg::PH_CMD2:  wbyte = second_cmd(s.op);
      nand_pkg::PH_STCMD: wbyte = `CMD_STATUS;
      default:            wbyte = `CMD_READ1;
    endcase
  end

  // Write phases; data-in stalls until a byte is held
  assign is_wr = s.phase inside {nand_pkg::PH_CMD1, nand_pkg::PH_ADDR, nand_pkg::PH_DIN,
                                 nand_pkg::PH_CMD2, nand_pkg::PH_STCMD, nand_pkg::PH_RDCMD};
  assign stall = (s.phase == nand_pkg::PH_DIN) && !s.hold_full && !s.half;
  assign len   = (s.op == nand_pkg::OP_SCAN) ? 13'h0001 : PAGE_BYTES;
  assign rec   = tbl.rd_rec;

  // Unknown codes, bad blocks other than for scan or reset, and out-of-order programs are refused
  always_comb begin
    refuse = 1'b0;
    if (s.op > nand_pkg::OP_SCAN) begin
      refuse = 1'b1;
    end else if (rec.bad && s.op != nand_pkg::OP_SCAN && s.op != nand_pkg::OP_RESET) begin
      refuse = 1'b1;
    end else if (s.op == nand_pkg::OP_PROG) begin
      refuse = !((7'(s.pg) >= rec.next_page) ||
                 ((7'(s.pg) + 7'h01 == rec.next_page) && (rec.pcount < `MAX_PARTIAL)));
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n          = s;
    n.done     = 1'b0;
    n.rd_valid = 1'b0;
    n.tbl_wr   = 1'b0;
    adv        = 1'b0;
    // Data-in fetch into the one-byte holding register
    if (s.wr_ready && wr_valid) begin
      n.hold      = wr_data;
      n.hold_full = 1'b1;
      n.fcnt      = s.fcnt + 13'h0001;
    end
    // Write byte: we_n low for a half cycle, device latches on the rise
    if (tick && is_wr && !stall) begin
      if (!s.half) begin
        n.we_n      = 1'b0;
        n.io_oe     = 1'b1;
        n.io_out    = wbyte;
        n.cle       = (s.phase != nand_pkg::PH_ADDR) && (s.phase != nand_pkg::PH_DIN);
        n.ale       = (s.phase == nand_pkg::PH_ADDR);
        n.half      = 1'b1;
        n.hold_full = (s.phase == nand_pkg::PH_DIN) ? 1'b0 : s.hold_full;
      end else begin
        n.we_n = 1'b1;
        n.half = 1'b0;
        adv    = 1'b1;
      end
    end
    // Read byte: bus released, sampled as read_strobe_n rises
    if (tick && (s.phase == nand_pkg::PH_STRD || s.phase == nand_pkg::PH_DOUT)) begin
      if (!s.half) begin
        n.re_n  = 1'b0;
        n.io_oe = 1'b0;
        n.cle   = 1'b0;
        n.ale   = 1'b0;
        n.half  = 1'b1;
      end else begin
        n.re_n = 1'b1;
        n.half = 1'b0;
        adv    = 1'b1;
      end
    end

    case (s.phase)
      nand_pkg::PH_INIT: begin
        // Only reset goes out while the device initialises
        n.boot = 1'b1;
        n.op   = nand_pkg::OP_RESET;
        n.ce_n = 1'b0;
        n.phase = nand_pkg::PH_CMD1;
      end
      nand_pkg::PH_IDLE: begin
        if (s.cmd_ready && cmd_valid) begin
          n.op    = nand_pkg::op_t'(cmd_op);
          n.blk   = cmd_block;
          n.pg    = (cmd_op == 3'(nand_pkg::OP_SCAN)) ? 6'h00 : cmd_page;
          n.col   = (cmd_op == 3'(nand_pkg::OP_SCAN)) ? BAD_COLUMN : 13'h0000;
          n.phase = nand_pkg::PH_LOOKUP;
        end
      end
      nand_pkg::PH_LOOKUP: begin
        n.phase = nand_pkg::PH_CHECK;
      end
      nand_pkg::PH_CHECK: begin
        n.res_fail    = 1'b0;
        n.res_rewrite = 1'b0;
        n.res_bad     = 1'b0;
        n.res_refused = refuse;
        n.status      = 8'h00;
        n.cnt         = 13'h0000;
        n.fcnt        = 13'h0000;
        n.hold_full   = 1'b0;
        if (refuse) begin
          n.done  = 1'b1;
          n.phase = nand_pkg::PH_IDLE;
        end else begin
          n.ce_n  = 1'b0;
          n.wp_n  = (s.op == nand_pkg::OP_PROG) || (s.op == nand_pkg::OP_ERASE);
          n.aidx  = (s.op == nand_pkg::OP_ERASE) ? 3'h2 : 3'h0;
          n.phase = nand_pkg::PH_CMD1;
          // Advance the page pointer or count a repeat on the last page
          if (s.op == nand_pkg::OP_PROG) begin
            n.tbl_wr = 1'b1;
            if (7'(s.pg) + 7'h01 == rec.next_page) begin
              n.tbl_rec = '{bad: 1'b0, next_page: rec.next_page, pcount: rec.pcount + 3'h1};
            end else begin
              n.tbl_rec = '{bad: 1'b0, next_page: 7'(s.pg) + 7'h01, pcount: 3'h1};
            end
          end
        end
      end
      nand_pkg::PH_CMD1: begin
        if (adv) begin
          n.phase = (s.op == nand_pkg::OP_RESET) ? nand_pkg::PH_WAITRB : nand_pkg::PH_ADDR;
          n.wcnt  = 4'h0;
        end
      end
      nand_pkg::PH_ADDR: begin
        // Exactly five address cycles, three for erase
        if (adv) begin
          n.aidx = s.aidx + 3'h1;
          if (s.aidx == 3'h4) begin
            n.phase = (s.op == nand_pkg::OP_PROG) ? nand_pkg::PH_DIN : nand_pkg::PH_CMD2;
          end
        end
      end
      nand_pkg::PH_DIN: begin
        // Whole page, so main and spare of each sector go together
        if (adv) begin
          n.cnt = s.cnt + 13'h0001;
          if (s.cnt + 13'h0001 == PAGE_BYTES) begin
            n.phase = nand_pkg::PH_CMD2;
          end
        end
      end
      nand_pkg::PH_CMD2: begin
        if (adv) begin
          n.phase = nand_pkg::PH_WAITRB;
          n.wcnt  = 4'h0;
        end
      end
      nand_pkg::PH_WAITRB: begin
        // Let busy assert first, then nothing is sent until ready
        n.cle   = 1'b0;
        n.ale   = 1'b0;
        n.io_oe = 1'b0;
        if (s.wcnt != 4'(`WB_CYC)) begin
          n.wcnt = s.wcnt + 4'h1;
        end else if (rb_sync) begin
          n.phase = (s.op == nand_pkg::OP_RESET) ? nand_pkg::PH_FINISH : nand_pkg::PH_STCMD;
        end
      end
      nand_pkg::PH_STCMD: begin
        if (adv) begin
          n.phase = nand_pkg::PH_STRD;
        end
      end
      nand_pkg::PH_STRD: begin
        if (adv) begin
          n.status = io_sync;
          n.phase  = (s.op == nand_pkg::OP_READ || s.op == nand_pkg::OP_SCAN) ?
                     nand_pkg::PH_RDCMD : nand_pkg::PH_FINISH;
        end
      end
      nand_pkg::PH_RDCMD: begin
        // 00h leaves status mode; output resumes at the latched column
        if (adv) begin
          n.phase = nand_pkg::PH_DOUT;
          n.cnt   = 13'h0000;
        end
      end
      nand_pkg::PH_DOUT: begin
        if (adv) begin
          n.rd_data  = io_sync;
          n.rd_valid = 1'b1;
          n.cnt      = s.cnt + 13'h0001;
          // Scan judges on the byte alone, ECC status is ignored
          if (s.op == nand_pkg::OP_SCAN && io_sync == `BAD_MARK) begin
            n.res_bad = 1'b1;
            n.tbl_wr  = 1'b1;
            n.tbl_rec = '{bad: 1'b1, next_page: 7'h00, pcount: 3'h0};
          end
          if (s.cnt + 13'h0001 == len) begin
            n.phase = nand_pkg::PH_FINISH;
          end
        end
      end
      nand_pkg::PH_FINISH: begin
        n.ce_n  = 1'b1;
        n.wp_n  = 1'b0;
        n.io_oe = 1'b0;
        n.boot  = 1'b0;
        n.done  = !s.boot;
        n.phase = nand_pkg::PH_IDLE;
        if (s.op != nand_pkg::OP_SCAN && s.op != nand_pkg::OP_RESET) begin
          n.res_fail = s.status[`ST_FAIL];
        end
        if (s.op == nand_pkg::OP_READ) begin
          n.res_rewrite = s.status[`ST_REWRITE];
        end
        // Failed program or erase bars the block; good erase resets it
        if (s.op == nand_pkg::OP_PROG && s.status[`ST_FAIL]) begin
          n.res_bad = 1'b1;
          n.tbl_wr  = 1'b1;
          n.tbl_rec = '{bad: 1'b1, next_page: 7'h00, pcount: 3'h0};
        end else if (s.op == nand_pkg::OP_ERASE) begin
          n.res_bad = s.status[`ST_FAIL];
          n.tbl_wr  = 1'b1;
          n.tbl_rec = '{bad: s.status[`ST_FAIL], next_page: 7'h00, pcount: 3'h0};
        end
      end
      default: begin
        n.phase = nand_pkg::PH_IDLE;
      end
    endcase

    n.cmd_ready = (n.phase == nand_pkg::PH_IDLE) && tbl.ready;
    n.wr_ready  = (n.phase == nand_pkg::PH_DIN) && !n.hold_full && (n.fcnt < PAGE_BYTES);
  end

  // Register the whole state; pins idle deselected, unprotected off
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s      <= '0;
      s.ce_n <= 1'b1;
      s.we_n <= 1'b1;
      s.re_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tbl.rd_blk    = s.blk;
  assign tbl.wr_en     = s.tbl_wr;
  assign tbl.wr_blk    = s.blk;
  assign tbl.wr_rec    = s.tbl_rec;
  assign cmd_ready     = s.cmd_ready;
  assign wr_ready      = s.wr_ready;
  assign rd_data       = s.rd_data;
  assign rd_valid      = s.rd_valid;
  assign done          = s.done;
  assign res_fail      = s.res_fail;
  assign res_refused   = s.res_refused;
  assign res_rewrite   = s.res_rewrite;
  assign res_bad       = s.res_bad;
  assign res_status    = s.status;
  assign cle           = s.cle;
  assign ale           = s.ale;
  assign ce_n          = s.ce_n;
  assign we_n          = s.we_n;
  assign read_strobe_n = s.re_n;
  assign wp_n          = s.wp_n;
  assign io_out        = s.io_out;
  assign io_oe         = s.io_oe;
endmodule
`default_nettype wire

// ===== verification/nand_host_checker.sv
// Port-level checks of the flash host controller.
// Assumes it is bound to nand_host_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module nand_host_checker (
  input wire logic       core_clk, nrst, cmd_valid, cmd_ready, done, res_refused,
  input wire logic       cle, ce_n, we_n, wp_n, io_oe, ready_busy_out, rd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [7:0] io_out
);
  logic       we_q;
  logic [7:0] last_cmd;
  wire        cmd_fall = cle && !we_n && we_q;
  wire        refuse   = cmd_valid && cmd_ready && cmd_op > 3'h4;
  // Previous command byte, so pairs of commands can be judged
  always_ff @(posedge core_clk) begin
    we_q <= we_n;
    if (!nrst) last_cmd <= 8'h00;
    else if (cmd_fall) last_cmd <= io_out;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_cmd_known: assert property (cmd_fall |-> io_out inside {8'h00, 8'h30, 8'h80, 8'h10,
    8'h60, 8'hD0, 8'h70, 8'hFF}) else $error("undefined command code");
  a_busy_cmds: assert property (cmd_fall && !ready_busy_out |-> io_out inside {8'h70, 8'h71, 8'hFF})
    else $error("command sent while busy");
  a_after_sdin: assert property (cmd_fall && last_cmd == 8'h80 |->
    io_out inside {8'h85, 8'h10, 8'h11, 8'hFF}) else $error("bad command after data input");
  a_wp_prog: assert property (cmd_fall && io_out inside {8'h10, 8'hD0} |-> wp_n)
    else $error("write protect low at confirm");
  a_reset_pins: assert property ($rose(nrst) |-> ce_n && we_n && !io_oe && !wp_n)
    else $error("pins not idle after reset");
  a_refuse_done: assert property (refuse |-> ##3 (done && res_refused))
    else $error("refusal not reported");
  a_refuse_quiet: assert property (refuse |=> we_n [*3])
    else $error("pins moved on refusal");
  a_wait_after: assert property (cmd_fall && io_out inside {8'h10, 8'h30, 8'hD0, 8'hFF} |=>
    (!cmd_fall) [*8]) else $error("command too soon after start");
  c_sdin: cover property (cmd_fall && io_out == 8'h80);
  c_refuse: cover property (done && res_refused);
  c_read: cover property (rd_valid);
endmodule
bind nand_host_ctrl nand_host_checker nand_host_checker_inst (.core_clk, .nrst, .cmd_valid, .cmd_ready, .done,
  .res_refused, .cle, .ce_n, .we_n, .wp_n, .io_oe, .ready_busy_out, .rd_valid, .cmd_op, .io_out);
`default_nettype wire

// ===== verification/nand_flash_model.sv
// Behavioural flash device answering the host controller pins.
// Assumes the bench supplies the ready/busy pull-up.
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model (
  input  wire logic       ce_n, cle, ale, we_n, read_strobe_n, wp_n, fail,
  input  wire logic [7:0] io_out,
  input  wire logic [3:0] bad_blk,
  output var  logic [7:0] io_in,
  output var  logic       rb_low
);
  logic [39:0] adr;
  logic [12:0] col;
  logic        st_mode = 1'b0;
  int          na;
  int          busy = 40;  // Power-up init keeps it busy
  assign rb_low = busy > 0;  // Open drain, low only when busy
  // Busy time runs down on its own, no clock at the device
  always #10 if (busy > 0) busy = busy - 1;
  // Command and address latching; status mode stays set until a 00h command
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      na = 0;
      st_mode <= io_out == 8'h70 || (st_mode && io_out != 8'h00);
      if (io_out == 8'h30) col <= adr[12:0];
      if (io_out inside {8'h10, 8'h30, 8'hD0, 8'hFF}) busy = 25;
    end else if (ale) begin
      if (na < 5) adr[na*8 +: 8] <= io_out;  // Sixth cycle dropped
      na = na + 1;
    end
  end
  // Sector parity is not modelled; fail stands for the ECC verdict
  // Status: bit7 not protected, 6..5 ready, bit3 rewrite on reads, bit0 fail
  always @(negedge read_strobe_n)
    io_in <= st_mode ? {wp_n, {2{busy == 0}}, 1'b0, fail & !wp_n, 2'h0, fail} :
             (adr[25:22] == bad_blk ? 8'h00 : col[7:0]);
  // Released bus shows the inverse, not a stale byte
  always @(posedge read_strobe_n) begin
    io_in <= ~io_in;
    if (!st_mode) col <= col + 13'h1;
  end
endmodule
`default_nettype wire

// ===== verification/nand_command_sequencing_rules_bench.sv
// Self-checking bench for the flash host controller.
// Assumes the flash model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module nand_command_sequencing_rules_bench;
  logic       core_clk = 0, nrst = 0, cmd_valid = 0, wr_valid = 0, fail = 0;
  logic [2:0] cmd_op = 0;
  logic [3:0] cmd_block = 0, blk, bad_blk = 4'h3;
  logic [5:0] cmd_page = 0, pg;
  logic [7:0] wr_data = 0, io_out, io_in, rd_data, res_status;
  logic       cmd_ready, wr_ready, rd_valid, done, res_fail, res_refused, res_rewrite, res_bad;
  logic       cle, ale, ce_n, we_n, read_strobe_n, wp_n, io_oe, rb_low;
  int         n_mismatch = 0, tests_run = 0, nrd, col0;
  wire        ready_busy_out = !rb_low;  // Pull-up on the open-drain line
  // Short page and small table keep the run brief
  // Three clocks per half so the two-flop synced read byte is fresh when sampled
  nand_host_ctrl #(.BLK_W(4), .NUM_BLOCKS(16), .PAGE_BYTES(13'h0040), .BAD_COLUMN(13'h0030), .HALF_CYC(3))
    nand_host_ctrl_inst (.core_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_block, .cmd_page, .wr_data,
    .wr_valid, .wr_ready, .rd_data, .rd_valid, .done, .res_fail, .res_refused, .res_rewrite, .res_bad,
    .res_status, .cle, .ale, .ce_n, .we_n, .read_strobe_n, .wp_n, .io_out, .io_oe, .io_in, .ready_busy_out);
  nand_flash_model nand_flash_model_inst (.ce_n, .cle, .ale, .we_n, .read_strobe_n, .wp_n, .fail, .io_out,
    .bad_blk, .io_in, .rb_low);
  always #5 core_clk = ~core_clk;
  function automatic logic [7:0] exp_byte(int c);
    return (cmd_block == bad_blk) ? 8'h00 : c[7:0];
  endfunction
  function automatic logic [7:0] exp_st(logic f);
    return {7'h70, f};
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One user command, bounded waits for take and done
  task automatic cmd(input int op, input logic [3:0] b, input logic [5:0] p);
    int t;
    t = 0;
    nrd = 0;
    cmd_op <= op[2:0];
    cmd_block <= b;
    cmd_page <= p;
    cmd_valid <= 1'b1;
    do @(posedge core_clk); while (cmd_ready !== 1'b1 && ++t < 20000);
    cmd_valid <= 1'b0;
    do @(posedge core_clk); while (done !== 1'b1 && ++t < 20000);
    chk(t < 20000, 1);
  endtask
  // Random write bytes with stalls; every read byte compared
  always @(posedge core_clk) begin
    wr_data <= 8'($urandom);
    wr_valid <= ($urandom % 4) != 0;
    if (rd_valid === 1'b1) begin
      chk(rd_data, exp_byte(col0 + nrd));
      nrd++;
    end
  end
  initial begin
    void'($urandom(32'h73A0FBB5));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (int op = 5; op < 8; op++) begin
      cmd(op, 4'h6, 0);
      chk(res_refused, 1);
    end
    blk = 4'h6 + 4'($urandom % 10);
    pg = 6'h01 + 6'($urandom % 60);
    col0 = 48;
    cmd(4, bad_blk, 0);
    chk(res_bad, 1);
    fail <= 1'b1;
    cmd(4, blk, 0);
    fail <= 1'b0;
    chk({res_bad, res_fail}, 2'b00);
    cmd(3, bad_blk, 0);
    chk(res_refused, 1);
    repeat (4) begin
      cmd(2, blk, pg);
      chk({res_refused, res_status}, {1'b0, exp_st(0)});
    end
    cmd(2, blk, pg);
    chk(res_refused, 1);
    cmd(2, blk, pg - 6'h01);
    chk(res_refused, 1);
    col0 = 0;
    cmd(1, blk, pg);
    chk({res_rewrite, res_status, nrd[6:0]}, {1'b0, 8'h60, 7'h40});
    fail <= 1'b1;
    cmd(3, blk, 0);
    chk(res_fail, 1);
    cmd(2, blk ^ 4'h1, 0);
    chk(res_fail, 1);
    cmd(1, blk ^ 4'h2, 0);
    chk({res_fail, res_rewrite, nrd[7:0]}, {2'b11, 8'h40});
    fail <= 1'b0;
    cmd(2, blk, pg + 6'h01);
    chk(res_refused, 1);
    cmd(1, blk ^ 4'h1, 0);
    chk(res_refused, 1);
    cmd(0, 0, 0);
    chk(res_refused, 0);
    end_sim;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire
